// ==== logic/pmm_pkg.sv ====
// package: register map, field layout, timing and state codes of the phy management master
`default_nettype none
package pmm_pkg;

  // register byte offsets on the apb side
  localparam logic [11:0] DATA_OFFSET      = 12'h0a4;
  localparam logic [11:0] CMD_OFFSET       = 12'h0a8;

  // field positions inside the command and data registers
  localparam int          CMD_BUSY_BIT     = 0;
  localparam int          CMD_WNR_BIT      = 1;
  localparam int          CMD_REG_LSB      = 6;
  localparam int          CMD_REG_MSB      = 10;
  localparam int          CMD_PHY_LSB      = 11;
  localparam int          CMD_PHY_MSB      = 15;
  localparam int          DATA_MSB         = 15;

  // values after reset
  localparam logic [15:0] DATA_RESET       = 16'h0000;
  localparam logic [4:0]  ADDR_RESET       = 5'h00;
  localparam logic        WNR_RESET        = 1'b0;

  // frame layout: preamble, start, opcode, turnaround, bit positions
  localparam logic [31:0] PREAMBLE         = 32'hffffffff;
  localparam logic [1:0]  START_CODE       = 2'h1;
  localparam logic [1:0]  OP_READ          = 2'h2;
  localparam logic [1:0]  OP_WRITE         = 2'h1;
  localparam logic [1:0]  TA_WRITE         = 2'h2;
  localparam logic [5:0]  TA_FIRST_BIT     = 6'h2e;
  localparam logic [5:0]  DATA_FIRST_BIT   = 6'h30;
  localparam logic [5:0]  FRAME_LAST_BIT   = 6'h3f;

  // timing figures in ns and the cycle counts derived from them
  localparam int          PCLK_PERIOD_NS   = 25;
  localparam int          MDC_PERIOD_NS    = 400;
  localparam int          LAUNCH_DELAY_NS  = 120;
  localparam int          SAMPLE_LEAD_NS   = 40;
  localparam int          MDC_PERIOD_CYC   = MDC_PERIOD_NS / PCLK_PERIOD_NS;
  localparam int          MDC_HALF_CYC     = MDC_PERIOD_CYC / 2;
  localparam int          LAUNCH_CYC       = LAUNCH_DELAY_NS / PCLK_PERIOD_NS;
  localparam int          SAMPLE_CYC       = (SAMPLE_LEAD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam logic [3:0]  PHASE_LAST       = 4'(MDC_PERIOD_CYC - 1);
  localparam logic [3:0]  PHASE_HIGH_END   = 4'(MDC_HALF_CYC);
  localparam logic [3:0]  PHASE_LAUNCH     = 4'(LAUNCH_CYC);
  localparam logic [3:0]  PHASE_SAMPLE     = 4'(MDC_PERIOD_CYC - SAMPLE_CYC);
  localparam logic [3:0]  PHASE_RESET      = 4'h0;

  // frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ARM  = 3'h2,
    ST_RUN  = 3'h4
  } pmm_state_t;

endpackage
`default_nettype wire

// ==== logic/pmm_tick_if.sv ====
// interface: management clock level and launch/sample strobes from the divider
`timescale 1ns/1ps
`default_nettype none
interface pmm_tick_if;
  logic mdc;
  logic launch;
  logic sample;
  modport src (output mdc, output launch, output sample);
  modport dst (input mdc, input launch, input sample);
endinterface
`default_nettype wire

// ==== logic/pmm_clkgen.sv ====
// module: free-running management clock divider with launch and sample strobes
`timescale 1ns/1ps
`default_nettype none
module pmm_clkgen (
  input  wire logic pclk,
  input  wire logic presetn,
  pmm_tick_if.src   tick
);

  typedef struct packed {
    logic [3:0] phase;
    logic       mdc;
    logic       launch;
    logic       sample;
  } pmm_clk_state_t;

  pmm_clk_state_t q_r;
  pmm_clk_state_t q_nxt;
  logic [3:0]     phase_inc;

  // phase walks the 16-cycle period; the clock never stops, even between frames
  always_comb begin
    q_nxt      = q_r;
    phase_inc  = (q_r.phase == pmm_pkg::PHASE_LAST) ? pmm_pkg::PHASE_RESET : q_r.phase + 4'h1;
    q_nxt.phase  = phase_inc;
    q_nxt.mdc    = (phase_inc < pmm_pkg::PHASE_HIGH_END);     // equal high and low halves
    q_nxt.launch = (phase_inc == pmm_pkg::PHASE_LAUNCH);      // data change after the rising edge
    q_nxt.sample = (phase_inc == pmm_pkg::PHASE_SAMPLE);      // capture ahead of the rising edge
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // start on the last phase so the first high half after reset is full length
      q_r.phase  <= pmm_pkg::PHASE_LAST;
      q_r.mdc    <= 1'b0;
      q_r.launch <= 1'b0;
      q_r.sample <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign tick.mdc    = q_r.mdc;
  assign tick.launch = q_r.launch;
  assign tick.sample = q_r.sample;

endmodule
`default_nettype wire

// ==== logic/pmm_sync.sv ====
// module: two-flop synchroniser for the returning management data lines
`timescale 1ns/1ps
`default_nettype none
module pmm_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } pmm_sync_state_t;

  pmm_sync_state_t q_r;
  pmm_sync_state_t q_nxt;

  // first stage feeds only the second; idle lines float high, so reset to ones
  always_comb begin
    q_nxt        = q_r;
    q_nxt.meta   = async_in;
    q_nxt.stable = q_r.meta;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sync_out = q_r.stable;

endmodule
`default_nettype wire

// ==== logic/pmm_top.sv ====
// module: apb-fronted phy management master that runs serial read and write frames
// Operation
// - run the management link at 2.5 MHz using the standard two-wire frame.
// - frames start with 32 ones, start bits 01, opcode 10 read or 01 write.
// - all address and data fields go out most significant bit first.
// - on writes the master drives turnaround 1 then 0, then data msb.
// - between frames the data line is released; the clock keeps running.
// - management clock period 400 ns with equal high and low time.
// - driven data changes about 120 ns after each rising clock edge.
// - incoming bits are captured about 40 ns before each rising edge.
// - reaches internal phys always, external pin phys only in mac mode.
// - data register at 0a4h, command register at 0a8h, indirect phy access.
// - data bits 15:0 read-write reset zero; bits 31:16 reserved read-only.
// - a read command places the returned phy value into the data register.
// - data read returns phy data when write-select is 0, host value when 1.
// - the write-only loader can write both registers and issue writes.
// - command bits 15:11 phy address, 10:6 register index, read-write, reset zero.
// - command bit 1 set selects write, cleared selects read.
// - writing the command starts a frame and sets busy bit 0 until done.
`timescale 1ns/1ps
`default_nettype none
module pmm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        loader_wr_en,
  input  wire logic [11:0] loader_addr,
  input  wire logic [31:0] loader_wdata,
  output logic             mgmt_busy_flag,
  input  wire logic        mac_mode,
  output logic             int_mgmt_clock,
  input  wire logic        int_mgmt_data_i,
  output logic             int_mgmt_data_o,
  output logic             int_mgmt_data_oe,
  output logic             port0_mgmt_clock_pin_o,
  output logic             port0_mgmt_clock_pin_oe,
  input  wire logic        port0_mgmt_data_pin_i,
  output logic             port0_mgmt_data_pin_o,
  output logic             port0_mgmt_data_pin_oe
);

  typedef struct packed {
    pmm_pkg::pmm_state_t st;
    logic [63:0]         frame;
    logic [5:0]          cnt;
    logic                oe;
    logic                dout;
    logic                is_read;
    logic [15:0]         rd_shift;
    logic [4:0]          target_a;
    logic [4:0]          phy_reg_index;
    logic                write_not_read_sel;
    logic [15:0]         data_wr;
    logic [15:0]         data_rd;
    logic [31:0]         prdata;
    logic                pslverr;
  } pmm_top_state_t;

  pmm_top_state_t q_r;
  pmm_top_state_t q_nxt;

  pmm_tick_if tick ();

  logic [1:0] sync_lines;
  logic       mdio_in;
  logic       apb_setup;
  logic       apb_wr;
  logic       wr_en;
  logic [1:0] wr_sel;
  logic [31:0] wr_data;
  logic [1:0] rd_sel;
  logic       busy;
  logic [15:0] data_view;

  // decode shared by the bus read, the bus write and the loader port
  function automatic logic [1:0] reg_sel(input logic [11:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr == pmm_pkg::DATA_OFFSET) begin
      sel = 2'h1;
    end else if (addr == pmm_pkg::CMD_OFFSET) begin
      sel = 2'h2;
    end
    return sel;
  endfunction

  // divider producing the management clock and the bit strobes
  pmm_clkgen u_clkgen (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick.src)
  );

  // both returning data lines come from outside the clock domain
  pmm_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({port0_mgmt_data_pin_i, int_mgmt_data_i}),
    .sync_out (sync_lines)
  );

  // external line only joins the wired-high read path in mac mode
  assign mdio_in = sync_lines[0] & (sync_lines[1] | ~mac_mode);

  // bus write wins over the loader when both arrive in one cycle
  always_comb begin
    apb_setup = psel & ~penable;
    apb_wr    = psel & penable & pwrite;
    wr_en     = apb_wr | loader_wr_en;
    wr_sel    = apb_wr ? reg_sel(paddr) : reg_sel(loader_addr);
    wr_data   = apb_wr ? pwdata : loader_wdata;
    rd_sel    = reg_sel(paddr);
    busy      = (q_r.st != pmm_pkg::ST_IDLE);
    data_view = q_r.write_not_read_sel ? q_r.data_wr : q_r.data_rd;
  end

  // register file, frame sequencer and read capture
  always_comb begin
    q_nxt = q_r;

    // data register write; host keeps it stable while busy
    if (wr_en && wr_sel == 2'h1) begin
      q_nxt.data_wr = wr_data[pmm_pkg::DATA_MSB:0];
    end

    // command write is taken only while idle and launches a frame
    if (wr_en && wr_sel == 2'h2 && !busy) begin
      q_nxt.target_a           = wr_data[pmm_pkg::CMD_PHY_MSB:pmm_pkg::CMD_PHY_LSB];
      q_nxt.phy_reg_index      = wr_data[pmm_pkg::CMD_REG_MSB:pmm_pkg::CMD_REG_LSB];
      q_nxt.write_not_read_sel = wr_data[pmm_pkg::CMD_WNR_BIT];
      q_nxt.is_read            = ~wr_data[pmm_pkg::CMD_WNR_BIT];
      q_nxt.frame = {pmm_pkg::PREAMBLE, pmm_pkg::START_CODE,
                     wr_data[pmm_pkg::CMD_WNR_BIT] ? pmm_pkg::OP_WRITE : pmm_pkg::OP_READ,
                     wr_data[pmm_pkg::CMD_PHY_MSB:pmm_pkg::CMD_PHY_LSB],
                     wr_data[pmm_pkg::CMD_REG_MSB:pmm_pkg::CMD_REG_LSB],
                     pmm_pkg::TA_WRITE,
                     q_r.data_wr};
      q_nxt.st = pmm_pkg::ST_ARM;                                  // busy rises here
    end

    unique case (q_r.st)
      pmm_pkg::ST_IDLE: begin
        q_nxt.oe   = 1'b0;                                         // line released between frames
        q_nxt.dout = 1'b1;
      end
      pmm_pkg::ST_ARM: begin
        // wait for a launch strobe so the first bit is a full period wide
        if (tick.launch) begin
          q_nxt.st   = pmm_pkg::ST_RUN;
          q_nxt.cnt  = 6'h00;
          q_nxt.oe   = 1'b1;
          q_nxt.dout = q_r.frame[63];                              // msb first
        end
      end
      pmm_pkg::ST_RUN: begin
        // capture read data bits shortly before the phy's next rising edge
        if (tick.sample && q_r.is_read && q_r.cnt >= pmm_pkg::DATA_FIRST_BIT) begin
          q_nxt.rd_shift = {q_r.rd_shift[14:0], mdio_in};
        end
        if (tick.launch) begin
          if (q_r.cnt == pmm_pkg::FRAME_LAST_BIT) begin
            q_nxt.st   = pmm_pkg::ST_IDLE;                         // busy self-clears
            q_nxt.oe   = 1'b0;
            q_nxt.dout = 1'b1;
            if (q_r.is_read) begin
              q_nxt.data_rd = q_nxt.rd_shift;
            end
          end else begin
            q_nxt.cnt   = q_r.cnt + 6'h01;
            q_nxt.frame = {q_r.frame[62:0], 1'b1};
            q_nxt.dout  = q_r.frame[62];
            // read frames hand the line to the phy from the first turnaround bit
            q_nxt.oe    = ~(q_r.is_read && (q_r.cnt + 6'h01) >= pmm_pkg::TA_FIRST_BIT);
          end
        end
      end
    endcase

    // read data and error are staged in the setup cycle so they come from flops
    if (apb_setup) begin
      q_nxt.pslverr = (rd_sel == 2'h0);
      unique case (rd_sel)
        2'h1:    q_nxt.prdata = {16'h0000, data_view};             // reserved high half reads zero
        2'h2:    q_nxt.prdata = {16'h0000, q_r.target_a, q_r.phy_reg_index, 4'h0,
                                 q_r.write_not_read_sel, busy};
        default: q_nxt.prdata = 32'h00000000;
      endcase
    end
  end

  // state register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r.st                 <= pmm_pkg::ST_IDLE;
      q_r.frame              <= '1;
      q_r.cnt                <= 6'h00;
      q_r.oe                 <= 1'b0;
      q_r.dout               <= 1'b1;
      q_r.is_read            <= 1'b0;
      q_r.rd_shift           <= pmm_pkg::DATA_RESET;
      q_r.target_a           <= pmm_pkg::ADDR_RESET;
      q_r.phy_reg_index      <= pmm_pkg::ADDR_RESET;
      q_r.write_not_read_sel <= pmm_pkg::WNR_RESET;
      q_r.data_wr            <= pmm_pkg::DATA_RESET;
      q_r.data_rd            <= pmm_pkg::DATA_RESET;
      q_r.prdata             <= 32'h00000000;
      q_r.pslverr            <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // apb answers in the access cycle with no wait states
  assign pready         = 1'b1;
  assign prdata         = q_r.prdata;
  assign pslverr        = q_r.pslverr;
  assign mgmt_busy_flag = (q_r.st != pmm_pkg::ST_IDLE);

  // internal phys always see the frame; pins only when acting as mac
  assign int_mgmt_clock          = tick.mdc;
  assign int_mgmt_data_o         = q_r.dout;
  assign int_mgmt_data_oe        = q_r.oe;
  assign port0_mgmt_clock_pin_o  = tick.mdc & mac_mode;
  assign port0_mgmt_clock_pin_oe = mac_mode;
  assign port0_mgmt_data_pin_o   = q_r.dout;
  assign port0_mgmt_data_pin_oe  = q_r.oe & mac_mode;

endmodule
`default_nettype wire

// ==== verification/pmm_properties.sv ====
// checker: port-level properties of the phy management master
`timescale 1ns/1ps
`default_nettype none
module pmm_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        mgmt_busy_flag,
  input wire logic        mac_mode,
  input wire logic        int_mgmt_clock,
  input wire logic        int_mgmt_data_o,
  input wire logic        int_mgmt_data_oe,
  input wire logic        port0_mgmt_clock_pin_o,
  input wire logic        port0_mgmt_clock_pin_oe,
  input wire logic        port0_mgmt_data_pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] bcnt_r;
  wire logic   acc = psel && penable;
  wire logic   mapped = paddr == pmm_pkg::DATA_OFFSET || paddr == pmm_pkg::CMD_OFFSET;
  // busy run length; a frame needs far fewer than 2047 cycles, so no wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bcnt_r <= 11'h000;
    else bcnt_r <= mgmt_busy_flag ? bcnt_r + 11'h001 : 11'h000;
  end
  chk_clock_high: assert property ($rose(int_mgmt_clock) |-> int_mgmt_clock [*8] ##1 !int_mgmt_clock)
    else $error("clock high time wrong");
  chk_clock_low: assert property ($fell(int_mgmt_clock) |-> !int_mgmt_clock [*8] ##1 int_mgmt_clock)
    else $error("clock low time wrong");
  // launches land mid high phase, well after the rising edge
  chk_launch_time: assert property ($changed(int_mgmt_data_o) || $changed(int_mgmt_data_oe) |->
    int_mgmt_clock && $past(int_mgmt_clock, 3)) else $error("data launched off phase");
  chk_idle_release: assert property (!mgmt_busy_flag |-> !int_mgmt_data_oe)
    else $error("data driven while idle");
  chk_pin_gating: assert property (port0_mgmt_data_pin_oe == (int_mgmt_data_oe && mac_mode) &&
    port0_mgmt_clock_pin_oe == mac_mode && port0_mgmt_clock_pin_o == (int_mgmt_clock && mac_mode))
    else $error("pin gating wrong");
  chk_busy_start: assert property (acc && pwrite && paddr == pmm_pkg::CMD_OFFSET && !mgmt_busy_flag
    |=> mgmt_busy_flag) else $error("busy not set");
  chk_busy_length: assert property ($fell(mgmt_busy_flag) |-> bcnt_r >= 11'h400 && bcnt_r <= 11'h412)
    else $error("frame length wrong");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_data_upper: assert property (acc && !pwrite && paddr == pmm_pkg::DATA_OFFSET |->
    prdata[31:16] == 16'h0000 && !pslverr) else $error("data upper bits set");
  cover property ($fell(mgmt_busy_flag));
  cover property (acc && pslverr);
  cover property (port0_mgmt_data_pin_oe);
endmodule
`default_nettype wire

// ==== verification/pmm_phy_model.sv ====
// partner: behavioural phy register slave on one management line
`timescale 1ns/1ps
`default_nettype none
module pmm_phy_model #(
  parameter logic [4:0] MY_ADDR = 5'h01
) (
  input  wire logic mgmt_clk,
  input  wire logic line,
  output logic      drv_o,
  output logic      drv_en
);
  logic [15:0] mem [32];
  logic [31:0] sr;
  logic [5:0]  ones;
  logic [4:0]  n, rg;
  logic        active, rd_hit, wr_hit;
  logic [1:0]  last_ta;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    {sr, ones, n, rg, active, rd_hit, wr_hit, last_ta, drv_o, drv_en} = '0;
  end
  // decode on rising edges; answers change just after the edge
  always @(posedge mgmt_clk) begin
    sr <= {sr[30:0], line};
    if (!active) begin
      ones   <= line ? ones + {5'h00, ones != 6'h3f} : 6'h00;
      active <= !line && ones >= 6'h20;
      n      <= 5'h01;
    end else begin
      n <= n + 5'h01;
      if (n == 5'h0d) begin
        rg     <= {sr[3:0], line};
        rd_hit <= sr[10:9] == 2'h2 && sr[8:4] == MY_ADDR;
        wr_hit <= sr[10:9] == 2'h1 && sr[8:4] == MY_ADDR;
      end
      if (n == 5'h0e && rd_hit) begin
        drv_en <= 1'b1;
        drv_o  <= 1'b0;
      end
      if (n >= 5'h0f && n <= 5'h1e) drv_o <= mem[rg][5'h1e - n];
      if (n == 5'h1f) begin
        drv_en <= 1'b0;
        active <= 1'b0;
        ones   <= 6'h00;
        if (wr_hit) mem[rg] <= {sr[14:0], line};
        if (wr_hit) last_ta <= sr[16:15];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_phy_mgmt_serial_master.sv ====
// testbench: register and frame checks of the phy management master
`timescale 1ns/1ps
`default_nettype none
module tb_phy_mgmt_serial_master;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ld_en = 1'b0, mac_mode = 1'b0, ierr, pready, pslverr, busy;
  logic [11:0] paddr = 12'h000, ld_addr = 12'h000;
  logic [31:0] pwdata = 32'h0, ld_data = 32'h0, prdata, rd;
  logic        iclk, ido, idoe, pco, pcoe, pdo, pdoe, ipd, ipen, epd, epen;
  // released lines float to the pull-up
  wire logic   int_line = (idoe ? ido : 1'b1) & (ipen ? ipd : 1'b1);
  wire logic   ext_line = (pdoe ? pdo : 1'b1) & (epen ? epd : 1'b1);
  wire logic   ext_clk = pcoe ? pco : 1'b0;
  int          error_cnt = 0, comparisons = 0, cycles = 0;
  pmm_top pmm_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loader_wr_en(ld_en), .loader_addr(ld_addr), .loader_wdata(ld_data),
    .mgmt_busy_flag(busy), .mac_mode(mac_mode), .int_mgmt_clock(iclk),
    .int_mgmt_data_i(int_line), .int_mgmt_data_o(ido), .int_mgmt_data_oe(idoe),
    .port0_mgmt_clock_pin_o(pco), .port0_mgmt_clock_pin_oe(pcoe),
    .port0_mgmt_data_pin_i(ext_line), .port0_mgmt_data_pin_o(pdo), .port0_mgmt_data_pin_oe(pdoe));
  pmm_phy_model #(.MY_ADDR(5'h01)) pmm_phy_model_int_inst (
    .mgmt_clk(iclk), .line(int_line), .drv_o(ipd), .drv_en(ipen));
  pmm_phy_model #(.MY_ADDR(5'h02)) pmm_phy_model_ext_inst (
    .mgmt_clk(ext_clk), .line(ext_line), .drv_o(epd), .drv_en(epen));
  always #12.5 pclk = ~pclk;
  // hang guard, well above the five frames of the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] cmdw(input logic [4:0] pa, input logic [4:0] ra, input logic wnr);
    return {16'h0, pa, ra, 4'h0, wnr, 1'b0};
  endfunction
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    ierr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ldr(input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    ld_en   <= 1'b1;
    ld_addr <= a;
    ld_data <= d;
    @(posedge pclk);
    ld_en   <= 1'b0;
  endtask
  task automatic wait_idle();
    repeat (1000) begin
      apb(1'b0, pmm_pkg::CMD_OFFSET, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    chk({31'h0, rd[0]}, 32'h0);
  endtask
  task automatic t_reset();
    apb(1'b0, pmm_pkg::DATA_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, pmm_pkg::CMD_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h0ac, 32'hffffffff);
    chk({31'h0, ierr}, 32'h1);
  endtask
  task automatic t_clock();
    int k;
    k = 0;
    while (iclk !== 1'b0) @(posedge pclk);
    while (iclk !== 1'b1) @(posedge pclk);
    while (iclk !== 1'b0) begin
      @(posedge pclk);
      k++;
    end
    while (iclk !== 1'b1) begin
      @(posedge pclk);
      k++;
    end
    chk(k, 32'h10);
  endtask
  task automatic t_write();
    apb(1'b1, pmm_pkg::DATA_OFFSET, 32'hffffa5c3); // data loaded before the command
    apb(1'b0, pmm_pkg::DATA_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, pmm_pkg::CMD_OFFSET, cmdw(5'h01, 5'h05, 1'b1));
    apb(1'b0, pmm_pkg::CMD_OFFSET, 32'h0);
    chk(rd, cmdw(5'h01, 5'h05, 1'b1) | 32'h1);
    apb(1'b0, pmm_pkg::DATA_OFFSET, 32'h0);
    chk(rd, 32'h0000a5c3);
    wait_idle();
    chk({16'h0, pmm_phy_model_int_inst.mem[5]}, 32'h0000a5c3);
    chk({30'h0, pmm_phy_model_int_inst.last_ta}, 32'h2);
    chk({31'h0, idoe}, 32'h0);
  endtask
  task automatic rd_frame(input logic [4:0] pa, input logic [4:0] ra);
    apb(1'b1, pmm_pkg::CMD_OFFSET, cmdw(pa, ra, 1'b0));
    wait_idle();
    apb(1'b0, pmm_pkg::DATA_OFFSET, 32'h0);
  endtask
  task automatic t_read();
    pmm_phy_model_int_inst.mem[9] = 16'h3c5a;
    rd_frame(5'h01, 5'h09);
    chk(rd, 32'h00003c5a);
  endtask
  // external phy only answers while the pins are enabled
  task automatic t_ext();
    mac_mode <= 1'b1;
    pmm_phy_model_ext_inst.mem[7] = 16'h1234;
    ldr(pmm_pkg::DATA_OFFSET, 32'h0000beef);
    ldr(pmm_pkg::CMD_OFFSET, cmdw(5'h02, 5'h03, 1'b1));
    wait_idle();
    chk({16'h0, pmm_phy_model_ext_inst.mem[3]}, 32'h0000beef);
    rd_frame(5'h02, 5'h07);
    chk(rd, 32'h00001234);
    mac_mode <= 1'b0;
    rd_frame(5'h02, 5'h07);
    chk(rd, 32'h0000ffff);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clock();
    t_write();
    t_read();
    t_ext();
    wrap_up();
  end
endmodule
bind pmm_top pmm_properties pmm_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .mgmt_busy_flag(mgmt_busy_flag),
  .mac_mode(mac_mode), .int_mgmt_clock(int_mgmt_clock), .int_mgmt_data_o(int_mgmt_data_o),
  .int_mgmt_data_oe(int_mgmt_data_oe), .port0_mgmt_clock_pin_o(port0_mgmt_clock_pin_o),
  .port0_mgmt_clock_pin_oe(port0_mgmt_clock_pin_oe), .port0_mgmt_data_pin_oe(port0_mgmt_data_pin_oe));
`default_nettype wire
